/* logic/dpsc_consts.svh */
// Reset values, strap encodings and port count for the downstream strap control
`ifndef DPSC_CONSTS_SVH
`define DPSC_CONSTS_SVH

// Number of downstream ports
`define DPSC_PORTS 4
// Sampled level of the shared power strap that selects ganged switching
`define DPSC_GANGED_SEL 1'b1
// Sampled level of the suspend strap that selects active-high enables
`define DPSC_POL_HIGH_SEL 1'b1
// Mode select level that picks the EEPROM master interface
`define DPSC_EEPROM_SEL 1'b1
// Fault input level that reports an overcurrent event
`define DPSC_FAULT_ACTIVE 1'b0
// Level driven on an indicator pin to light its lamp (active low pin)
`define DPSC_LED_ON 1'b0
// Level driven when an open-drain serial pin is pulled low
`define DPSC_SERIAL_LOW 1'b0
// Reset value of every captured per-port field
`define DPSC_PORT_RST 4'h0

`endif

/* logic/dpsc_pkg.sv */
// Types shared by the downstream strap control logic
package dpsc_pkg;

  // Capture cycle after reset release, then normal running
  typedef enum logic {
    DPSC_HOLD,
    DPSC_RUN
  } dpsc_state_t;

endpackage : dpsc_pkg

/* logic/dpsc_strap_ctrl.sv */
// Downstream port power, fault, indicator and reset-strap capture logic
`include "dpsc_consts.svh"

module dpsc_strap_ctrl #(
  parameter int PORTS = `DPSC_PORTS
) (
  input wire logic clk,
  input wire logic srst,
  // Power/charge pins, two-way
  input wire logic [PORTS-1:0] port_power_charge_pin_in,
  output logic [PORTS-1:0] port_power_charge_pin_out,
  output logic [PORTS-1:0] port_power_charge_pin_oe,
  // Per-port power requests from the hub core, active high
  input wire logic [PORTS-1:0] port_power_request,
  // Fault inputs from the power switches, active low
  input wire logic [PORTS-1:0] port_fault_input_n,
  // Amber indicator pins, two-way
  input wire logic [PORTS-1:0] amber_removable_pin_in,
  output logic [PORTS-1:0] amber_removable_pin_out,
  output logic [PORTS-1:0] amber_removable_pin_oe,
  input wire logic [PORTS-1:0] amber_led_request,
  // Green indicator pins, two-way
  input wire logic [PORTS-1:0] green_port_used_pin_in,
  output logic [PORTS-1:0] green_port_used_pin_out,
  output logic [PORTS-1:0] green_port_used_pin_oe,
  input wire logic [PORTS-1:0] green_led_request,
  // Straps and mode pins
  input wire logic shared_power_strap,
  input wire logic highspeed_suspend_pin_in,
  input wire logic serial_mode_select,
  // Open-drain serial pins
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  // Pull-low requests from the EEPROM master and SMBus slave engines
  input wire logic eeprom_clock_pull,
  input wire logic eeprom_data_pull,
  input wire logic smbus_clock_pull,
  input wire logic smbus_data_pull,
  // Loaded configuration: presence and low-power disable bit
  input wire logic ext_config_present,
  input wire logic low_power_state_disable_bit,
  // Captured configuration and status
  output logic [PORTS-1:0] battery_charge_support,
  output logic [PORTS-1:0] removable_config,
  output logic [PORTS-1:0] port_used_config,
  output logic [PORTS-1:0] port_overcurrent,
  output logic ganged_mode,
  output logic power_active_high,
  output logic eeprom_mode,
  output logic u1u2_disable,
  output logic u1u2_no_initiate,
  output logic straps_valid
);

  typedef struct packed {
    dpsc_pkg::dpsc_state_t st;
    logic [PORTS-1:0] bc;
    logic [PORTS-1:0] rmbl;
    logic [PORTS-1:0] used;
    logic [PORTS-1:0] oc;
    logic [PORTS-1:0] pwr_out;
    logic [PORTS-1:0] pwr_oe;
    logic [PORTS-1:0] amb_out;
    logic [PORTS-1:0] amb_oe;
    logic [PORTS-1:0] grn_out;
    logic [PORTS-1:0] grn_oe;
    logic ganged;
    logic pol_high;
    logic strap_scl;
    logic strap_sda;
    logic eeprom;
    logic scl_oe;
    logic sda_oe;
    logic scl_out;
    logic sda_out;
    logic u1u2_dis;
    logic u1u2_noinit;
    logic valid;
  } dpsc_regs_t;

  dpsc_regs_t s;
  dpsc_regs_t next_s;

  // Pin level that requests power, given the sampled polarity
  function automatic logic power_level(input logic en, input logic pol_high);
    power_level = pol_high ? en : ~en;
  endfunction : power_level

  // Next state: one capture cycle after release, then steady control
  always_comb begin
    next_s = s;
    case (s.st)
      dpsc_pkg::DPSC_HOLD: begin
        // All pins still undriven here, so the pins show their straps
        // ganged strap
        next_s.ganged = (shared_power_strap == `DPSC_GANGED_SEL);
        next_s.pol_high = (highspeed_suspend_pin_in == `DPSC_POL_HIGH_SEL);
        next_s.bc = (shared_power_strap == `DPSC_GANGED_SEL) ?
                    {PORTS{port_power_charge_pin_in[0]}} : port_power_charge_pin_in;
        next_s.rmbl = amber_removable_pin_in;
        next_s.used = green_port_used_pin_in;
        next_s.strap_scl = serial_clock_pin_in;
        next_s.strap_sda = serial_data_pin_in;
        next_s.valid = 1'b1;
        next_s.st = dpsc_pkg::DPSC_RUN;
      end
      dpsc_pkg::DPSC_RUN: begin
        for (int i = 0; i < PORTS; i++) begin
          next_s.pwr_out[i] = power_level(s.ganged ? port_power_request[0] :
                                          port_power_request[i], s.pol_high);
          // fault is active low; ganged shares port 0 sensing
          next_s.oc[i] = s.ganged ? (port_fault_input_n[0] == `DPSC_FAULT_ACTIVE) :
                         (port_fault_input_n[i] == `DPSC_FAULT_ACTIVE);
          // lamps only once straps are held
          next_s.amb_out[i] = amber_led_request[i] ? `DPSC_LED_ON : ~`DPSC_LED_ON;
          next_s.grn_out[i] = green_led_request[i] ? `DPSC_LED_ON : ~`DPSC_LED_ON;
        end
        next_s.pwr_oe = {PORTS{1'b1}};
        next_s.amb_oe = {PORTS{1'b1}};
        next_s.grn_oe = {PORTS{1'b1}};
        next_s.eeprom = (serial_mode_select == `DPSC_EEPROM_SEL);
        next_s.scl_oe = (serial_mode_select == `DPSC_EEPROM_SEL) ?
                        eeprom_clock_pull : smbus_clock_pull;
        next_s.sda_oe = (serial_mode_select == `DPSC_EEPROM_SEL) ?
                        eeprom_data_pull : smbus_data_pull;
        // Open drain: only ever pull low, the resistor gives the high
        next_s.scl_out = `DPSC_SERIAL_LOW;
        next_s.sda_out = `DPSC_SERIAL_LOW;
        // loaded bit wins; data strap sets both, clock strap only sets no-initiate
        if (ext_config_present) begin
          next_s.u1u2_dis = low_power_state_disable_bit;
          next_s.u1u2_noinit = low_power_state_disable_bit;
        end else begin
          next_s.u1u2_dis = s.strap_sda;
          next_s.u1u2_noinit = s.strap_sda | s.strap_scl;
        end
      end
      default: begin
        next_s.st = dpsc_pkg::DPSC_HOLD;
      end
    endcase
    // Reset releases every pin so the straps can settle
    if (srst) begin
      next_s = '0;
      next_s.st = dpsc_pkg::DPSC_HOLD;
      next_s.bc = `DPSC_PORT_RST;
      next_s.rmbl = `DPSC_PORT_RST;
      next_s.used = `DPSC_PORT_RST;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    s <= next_s;
  end

  // Outputs straight from the state register
  assign port_power_charge_pin_out = s.pwr_out;
  assign port_power_charge_pin_oe = s.pwr_oe;
  assign amber_removable_pin_out = s.amb_out;
  assign amber_removable_pin_oe = s.amb_oe;
  assign green_port_used_pin_out = s.grn_out;
  assign green_port_used_pin_oe = s.grn_oe;
  assign serial_clock_pin_out = s.scl_out;
  assign serial_clock_pin_oe = s.scl_oe;
  assign serial_data_pin_out = s.sda_out;
  assign serial_data_pin_oe = s.sda_oe;
  assign battery_charge_support = s.bc;
  assign removable_config = s.rmbl;
  assign port_used_config = s.used;
  assign port_overcurrent = s.oc;
  assign ganged_mode = s.ganged;
  assign power_active_high = s.pol_high;
  assign eeprom_mode = s.eeprom;
  assign u1u2_disable = s.u1u2_dis;
  assign u1u2_no_initiate = s.u1u2_noinit;
  assign straps_valid = s.valid;

  // Checks on the captured straps and the driven pins
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Sampled reset too: the release edge itself still resets the state
  sequence seq_capture;
    s.st == dpsc_pkg::DPSC_HOLD && !srst;
  endsequence

  sequence seq_running;
    s.st == dpsc_pkg::DPSC_RUN ##1 s.st == dpsc_pkg::DPSC_RUN;
  endsequence

  chk_charge_capture: assert property (
    seq_capture |=> battery_charge_support == ($past(shared_power_strap) ?
      {PORTS{$past(port_power_charge_pin_in[0])}} : $past(port_power_charge_pin_in))
  ) else $error("charging support not captured from pins");

  chk_power_drive: assert property (
    seq_running |-> port_power_charge_pin_oe == {PORTS{1'b1}}
  ) else $error("power pins not driven while running");

  chk_ganged_power: assert property (
    seq_running ##0 ganged_mode |=>
      port_power_charge_pin_out == {PORTS{power_level($past(port_power_request[0]),
                                                      power_active_high)}}
  ) else $error("ganged power not taken from port 0");

  chk_polarity: assert property (
    s.st == dpsc_pkg::DPSC_RUN && !ganged_mode |=>
      port_power_charge_pin_out[0] == (power_active_high ? $past(port_power_request[0]) :
                                       !$past(port_power_request[0]))
  ) else $error("power enable polarity wrong");

  chk_fault_map: assert property (
    s.st == dpsc_pkg::DPSC_RUN && !ganged_mode |=> port_overcurrent == ~$past(port_fault_input_n)
  ) else $error("fault input polarity wrong");

  chk_led_straps: assert property (
    seq_capture |=> removable_config == $past(amber_removable_pin_in) &&
                    port_used_config == $past(green_port_used_pin_in)
  ) else $error("indicator straps not captured");

  chk_led_quiet: assert property (
    !straps_valid |-> amber_removable_pin_oe == '0 && green_port_used_pin_oe == '0
  ) else $error("indicator pin driven before capture");

  chk_serial_mode: assert property (
    s.st == dpsc_pkg::DPSC_RUN |=> eeprom_mode == $past(serial_mode_select) &&
      serial_data_pin_oe == ($past(serial_mode_select) ? $past(eeprom_data_pull) :
                             $past(smbus_data_pull))
  ) else $error("serial pins not steered by mode");

  chk_low_power: assert property (
    seq_running ##0 !ext_config_present ##1 s.strap_sda |-> u1u2_disable && u1u2_no_initiate
  ) else $error("data strap did not disable U1/U2");

  chk_cfg_override: assert property (
    s.st == dpsc_pkg::DPSC_RUN && ext_config_present |=>
      u1u2_disable == $past(low_power_state_disable_bit)
  ) else $error("loaded bit did not set U1/U2");

  chk_mode_straps: assert property (
    seq_capture |=> ganged_mode == $past(shared_power_strap) &&
                    power_active_high == $past(highspeed_suspend_pin_in)
  ) else $error("ganged or polarity strap not captured");

  chk_serial_straps: assert property (
    seq_capture |=> s.strap_scl == $past(serial_clock_pin_in) &&
                    s.strap_sda == $past(serial_data_pin_in)
  ) else $error("serial pin straps not captured");

  chk_clock_strap: assert property (
    seq_running ##0 !ext_config_present ##1 s.strap_scl |-> u1u2_no_initiate
  ) else $error("clock strap did not stop U1/U2 initiation");

  chk_data_strap_low: assert property (
    seq_running ##0 !ext_config_present ##1 !s.strap_sda |-> !u1u2_disable
  ) else $error("data strap low did not enable U1/U2");

  chk_clock_steer: assert property (
    s.st == dpsc_pkg::DPSC_RUN |=>
      serial_clock_pin_oe == ($past(serial_mode_select) ? $past(eeprom_clock_pull) :
                              $past(smbus_clock_pull))
  ) else $error("serial clock pin not steered by mode");

  chk_capture_hold: assert property (
    seq_running |-> $stable(battery_charge_support) && $stable(removable_config) &&
                    $stable(port_used_config)
  ) else $error("captured configuration changed while running");

endmodule : dpsc_strap_ctrl

/* test/dpsc_far_side_model.sv */
// Far-side model: strap resistors, power switches and serial pull resistors
module dpsc_far_side_model (
  input wire logic [3:0] port_power_charge_pin_out,
  input wire logic [3:0] port_power_charge_pin_oe,
  input wire logic [3:0] amber_removable_pin_out,
  input wire logic [3:0] amber_removable_pin_oe,
  input wire logic [3:0] green_port_used_pin_out,
  input wire logic [3:0] green_port_used_pin_oe,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe,
  input wire logic serial_data_pin_out,
  input wire logic serial_data_pin_oe,
  input wire logic [3:0] pwr_strap,
  input wire logic [3:0] amb_strap,
  input wire logic [3:0] grn_strap,
  input wire logic scl_strap,
  input wire logic sda_strap,
  input wire logic [3:0] fault_event,
  output logic [3:0] port_power_charge_pin_in,
  output logic [3:0] amber_removable_pin_in,
  output logic [3:0] green_port_used_pin_in,
  output logic serial_clock_pin_in,
  output logic serial_data_pin_in,
  output logic [3:0] port_fault_input_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pins settle to the strap resistor level
  assign port_power_charge_pin_in = (port_power_charge_pin_oe & port_power_charge_pin_out)
    | (~port_power_charge_pin_oe & pwr_strap);
  assign amber_removable_pin_in = (amber_removable_pin_oe & amber_removable_pin_out)
    | (~amber_removable_pin_oe & amb_strap);
  assign green_port_used_pin_in = (green_port_used_pin_oe & green_port_used_pin_out)
    | (~green_port_used_pin_oe & grn_strap);
  // Open drain: only a low can be forced, otherwise the resistor wins
  assign serial_clock_pin_in = (serial_clock_pin_oe && !serial_clock_pin_out) ? 1'b0 : scl_strap;
  assign serial_data_pin_in = (serial_data_pin_oe && !serial_data_pin_out) ? 1'b0 : sda_strap;
  assign port_fault_input_n = ~fault_event;
endmodule : dpsc_far_side_model

/* test/dpsc_strap_ctrl_tb_top.sv */
// Bench for the downstream strap control: capture and run checks
module dpsc_strap_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, shared_power_strap, highspeed_suspend_pin_in, serial_mode_select;
  logic eeprom_clock_pull, eeprom_data_pull, smbus_clock_pull, smbus_data_pull;
  logic ext_config_present, low_power_state_disable_bit, scl_strap, sda_strap;
  logic serial_clock_pin_in, serial_clock_pin_out, serial_clock_pin_oe;
  logic serial_data_pin_in, serial_data_pin_out, serial_data_pin_oe, straps_valid;
  logic ganged_mode, power_active_high, eeprom_mode, u1u2_disable, u1u2_no_initiate;
  logic [3:0] port_power_charge_pin_in, port_power_charge_pin_out, port_power_charge_pin_oe;
  logic [3:0] amber_removable_pin_in, amber_removable_pin_out, amber_removable_pin_oe;
  logic [3:0] green_port_used_pin_in, green_port_used_pin_out, green_port_used_pin_oe;
  logic [3:0] port_power_request, port_fault_input_n, amber_led_request, green_led_request;
  logic [3:0] battery_charge_support, removable_config, port_used_config, port_overcurrent;
  logic [3:0] pwr_strap, amb_strap, grn_strap, fault_event, pat;
  logic [15:0] cfg;
  int n_errors, comparisons, cycles;
  // Strap sets: power, amber, green, then ganged, polarity, clock, data
  localparam logic [15:0] CFGS [4] = '{16'h5a30, 16'ha5c6, 16'h3c99, 16'hc61f};

  dpsc_strap_ctrl #(.PORTS(4)) i_dpsc_strap_ctrl (
    .clk, .srst, .port_power_charge_pin_in, .port_power_charge_pin_out,
    .port_power_charge_pin_oe, .port_power_request, .port_fault_input_n,
    .amber_removable_pin_in, .amber_removable_pin_out, .amber_removable_pin_oe,
    .amber_led_request, .green_port_used_pin_in, .green_port_used_pin_out,
    .green_port_used_pin_oe, .green_led_request, .shared_power_strap,
    .highspeed_suspend_pin_in, .serial_mode_select, .serial_clock_pin_in,
    .serial_clock_pin_out, .serial_clock_pin_oe, .serial_data_pin_in, .serial_data_pin_out,
    .serial_data_pin_oe, .eeprom_clock_pull, .eeprom_data_pull, .smbus_clock_pull,
    .smbus_data_pull, .ext_config_present, .low_power_state_disable_bit,
    .battery_charge_support, .removable_config, .port_used_config, .port_overcurrent,
    .ganged_mode, .power_active_high, .eeprom_mode, .u1u2_disable, .u1u2_no_initiate,
    .straps_valid
  );

  dpsc_far_side_model i_dpsc_far_side_model (
    .port_power_charge_pin_out, .port_power_charge_pin_oe, .amber_removable_pin_out,
    .amber_removable_pin_oe, .green_port_used_pin_out, .green_port_used_pin_oe,
    .serial_clock_pin_out, .serial_clock_pin_oe, .serial_data_pin_out, .serial_data_pin_oe,
    .pwr_strap, .amb_strap, .grn_strap, .scl_strap, .sda_strap, .fault_event,
    .port_power_charge_pin_in, .amber_removable_pin_in, .green_port_used_pin_in,
    .serial_clock_pin_in, .serial_data_pin_in, .port_fault_input_n
  );

  // Free-running core clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard, well beyond the seventy or so cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // Present a strap set, reset, and let the capture edge pass
  task automatic restart();
    @(posedge clk);
    {pwr_strap, amb_strap, grn_strap} <= cfg[15:4];
    {shared_power_strap, highspeed_suspend_pin_in, scl_strap, sda_strap} <= cfg[3:0];
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({port_power_charge_pin_oe, amber_removable_pin_oe, straps_valid}, 9'h000);
    @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(straps_valid, 1'b1);
  endtask : restart

  // One run-state stimulus, checked one edge later
  task automatic apply(input int j, input int c);
    @(posedge clk);
    pat = 4'h9 ^ (4'h3 << j);
    port_power_request <= pat;
    fault_event <= {pat[0], pat[3:1]};
    amber_led_request <= pat;
    green_led_request <= ~pat;
    {eeprom_clock_pull, eeprom_data_pull, smbus_clock_pull, smbus_data_pull} <= pat;
    serial_mode_select <= j[0];
    ext_config_present <= j[1];
    low_power_state_disable_bit <= j[0] ^ c[0];
    @(posedge clk);
    @(negedge clk);
    check(battery_charge_support, cfg[3] ? {4{cfg[12]}} : cfg[15:12]);
    check({removable_config, port_used_config}, cfg[11:4]);
    check({ganged_mode, power_active_high}, cfg[3:2]);
    check(port_power_charge_pin_out, (cfg[3] ? {4{pat[0]}} : pat) ^ {4{~cfg[2]}});
    check(port_power_charge_pin_oe, 4'hf);
    check(port_overcurrent, cfg[3] ? {4{pat[1]}} : {pat[0], pat[3:1]});
    check({amber_removable_pin_out, green_port_used_pin_out}, {~pat, pat});
    check({amber_removable_pin_oe, green_port_used_pin_oe}, 8'hff);
    check(eeprom_mode, j[0]);
    check({serial_clock_pin_oe, serial_data_pin_oe}, j[0] ? pat[3:2] : pat[1:0]);
    check({serial_clock_pin_out, serial_data_pin_out}, 2'h0);
    check(u1u2_disable, j[1] ? j[0] ^ c[0] : cfg[0]);
    check(u1u2_no_initiate, j[1] ? j[0] ^ c[0] : cfg[0] | cfg[1]);
  endtask : apply

  // Main sequence: every strap set, straps disturbed after capture
  initial begin
    srst = 1'b1;
    {port_power_request, fault_event, amber_led_request, green_led_request} = 16'h0000;
    {pwr_strap, amb_strap, grn_strap, shared_power_strap} = 13'h0000;
    {highspeed_suspend_pin_in, serial_mode_select, scl_strap, sda_strap} = 4'h0;
    {eeprom_clock_pull, eeprom_data_pull, smbus_clock_pull, smbus_data_pull} = 4'h0;
    {ext_config_present, low_power_state_disable_bit} = 2'h0;
    n_errors = 0;
    comparisons = 0;
    for (int c = 0; c < 4; c++) begin
      cfg = CFGS[c];
      restart();
      @(posedge clk);
      {pwr_strap, amb_strap, grn_strap} <= ~cfg[15:4];
      {shared_power_strap, highspeed_suspend_pin_in, scl_strap, sda_strap} <= ~cfg[3:0];
      for (int j = 0; j < 4; j++) begin
        apply(j, c);
      end
    end
    close_out();
  end
endmodule : dpsc_strap_ctrl_tb_top
